// ===== hdl/fifo_flag_core.sv
// Status-flag FIFO core: link sampling, offset load, store, read path and flags
`timescale 1ns/1ps
module fifo_flag_core #(
   parameter int DEPTH = fifo_pkg::DEPTH_DEFAULT
) (
   input  wire logic                        CLOCK_IN,
   input  wire logic                        RSTN_IN,
   input  wire logic                        MASTER_RESET_N_IN,
   input  wire logic                        FIRST_LOAD_N_IN,
   input  wire logic                        READ_EXPANSION_N_IN,
   input  wire logic                        WRITE_EXPANSION_N_IN,
   input  wire logic                        OFFSET_LOAD_N_IN,
   input  wire logic                        WRITE_CLOCK_IN,
   input  wire logic                        WRITE_ENABLE_N_IN,
   input  wire logic [fifo_pkg::DATA_W-1:0] DATA_IN,
   input  wire logic                        READ_CLOCK_IN,
   input  wire logic                        READ_ENABLE_N_IN,
   output logic      [fifo_pkg::DATA_W-1:0] DATA_OUT,
   output logic                             EMPTY_FLAG_N_OUT,
   output logic                             FULL_FLAG_N_OUT,
   output logic                             HALF_FULL_FLAG_N_OUT,
   output logic                             ALMOST_EMPTY_FLAG_N_OUT,
   output logic                             ALMOST_FULL_FLAG_N_OUT,
   output logic                             FALL_THROUGH_MODE_OUT
);

   localparam int AW    = $clog2(DEPTH);
   localparam int CW    = AW + 1;
   localparam int CMP_W = 14;
   localparam int DW    = fifo_pkg::DATA_W;
   localparam logic [CW-1:0]    DEPTH_C = CW'(DEPTH);
   localparam logic [CMP_W-1:0] DEPTH_W = CMP_W'(DEPTH);
   localparam logic [CMP_W-1:0] HALF_W  = CMP_W'(DEPTH / 2);
   localparam logic [1:0]       LAST_T  = 2'(fifo_pkg::FALL_THROUGH_MODE_TRANSITIONS - 1);

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   // Every outside pin runs through the same three stages, so data and
   // enables seen at stage three line up with the clock edge found there.
   fifo_pkg::pins_s raw;
   fifo_pkg::pins_s s1;
   fifo_pkg::pins_s s2;
   fifo_pkg::pins_s s3;
   fifo_pkg::pins_s next_s1;
   fifo_pkg::pins_s next_s2;
   fifo_pkg::pins_s next_s3;
   logic            wclk_st;
   logic            rclk_st;
   logic            next_wclk_st;
   logic            next_rclk_st;

   assign raw = '{mrs_n: MASTER_RESET_N_IN, fl_n: FIRST_LOAD_N_IN,
                  rxi_n: READ_EXPANSION_N_IN, wxi_n: WRITE_EXPANSION_N_IN,
                  ld_n: OFFSET_LOAD_N_IN, wen_n: WRITE_ENABLE_N_IN,
                  ren_n: READ_ENABLE_N_IN, wclk: WRITE_CLOCK_IN,
                  rclk: READ_CLOCK_IN, data: DATA_IN};

   // A level is accepted only when stages two and three agree
   function automatic logic settle(input logic b2, input logic b3, input logic st);
      return (b2 == b3) ? b3 : st;
   endfunction : settle

   always_comb begin
      next_s1      = raw;    // R18
      next_s2      = s1;     // R18
      next_s3      = s2;     // R18
      next_wclk_st = settle(s2.wclk, s3.wclk, wclk_st); // R18
      next_rclk_st = settle(s2.rclk, s3.rclk, rclk_st); // R18
   end

   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         s1      <= '0;
         s2      <= '0;
         s3      <= '0;
         wclk_st <= 1'b0;
         rclk_st <= 1'b0;
      end else begin
         s1      <= next_s1;
         s2      <= next_s2;
         s3      <= next_s3;
         wclk_st <= next_wclk_st;
         rclk_st <= next_rclk_st;
      end
   end

   logic wr_rise;
   logic rd_trans;
   logic rd_rise;

   assign wr_rise  = next_wclk_st & ~wclk_st;
   assign rd_trans = next_rclk_st ^ rclk_st;
   assign rd_rise  = rd_trans & ~rclk_st;

   // ----------------------------------------------------------------
   // Core state
   // ----------------------------------------------------------------
   logic                           fall_through_mode;
   logic [CW-1:0]                  mem_count;
   logic [AW-1:0]                  wr_ptr;
   logic [AW-1:0]                  rd_ptr;
   logic [1:0][DW-1:0]             buf_data;
   logic [1:0]                     buf_count;
   logic [fifo_pkg::OFFSET_W-1:0]  empty_off;
   logic [fifo_pkg::OFFSET_W-1:0]  full_off;
   logic                           load_sel;
   fifo_pkg::rd_state_e            rd_state;
   logic [1:0]                     trans_cnt;
   logic                           out_valid;
   logic [DW-1:0]                  data_out;
   fifo_pkg::flags_s               flags;

   logic                           next_fall_through_mode;
   logic [CW-1:0]                  next_mem_count;
   logic [AW-1:0]                  next_wr_ptr;
   logic [AW-1:0]                  next_rd_ptr;
   logic [1:0][DW-1:0]             next_buf_data;
   logic [1:0]                     next_buf_count;
   logic [fifo_pkg::OFFSET_W-1:0]  next_empty_off;
   logic [fifo_pkg::OFFSET_W-1:0]  next_full_off;
   logic                           next_load_sel;
   fifo_pkg::rd_state_e            next_rd_state;
   logic [1:0]                     next_trans_cnt;
   logic                           next_out_valid;
   logic [DW-1:0]                  next_data_out;
   fifo_pkg::flags_s               next_flags;

   logic                           mem_wr;
   logic                           mem_rd;
   logic [DW-1:0]                  rd_data;
   logic                           buf_in_valid;
   logic                           buf_in_ready;
   logic                           buf_out_valid;
   logic                           buf_out_ready;
   logic                           room;
   logic [CMP_W-1:0]               cnt_w;

   // Two-entry buffer between the write port and the store; the store
   // side stalls whenever it has no free word.
   assign buf_in_ready  = (buf_count != 2'h2);
   assign buf_out_valid = (buf_count != 2'h0);
   assign buf_out_ready = s3.mrs_n && (mem_count < DEPTH_C);
   assign room          = (mem_count + CW'(buf_count)) < DEPTH_C;
   assign buf_in_valid  = wr_rise && s3.mrs_n && !s3.wen_n && s3.ld_n; // R4

   fifo_ram #(
      .WIDTH (DW),
      .DEPTH (DEPTH)
   ) u_ram (
      .clock_in    (CLOCK_IN),
      .wr_en_in    (mem_wr),
      .wr_addr_in  (wr_ptr),
      .wr_data_in  (buf_data[0]),
      .rd_en_in    (mem_rd),
      .rd_addr_in  (rd_ptr),
      .rd_data_out (rd_data)
   );

   always_comb begin
      next_fall_through_mode      = fall_through_mode;
      next_mem_count = mem_count;
      next_wr_ptr    = wr_ptr;
      next_rd_ptr    = rd_ptr;
      next_buf_data  = buf_data;
      next_buf_count = buf_count;
      next_empty_off = empty_off;
      next_full_off  = full_off;
      next_load_sel  = load_sel;
      next_rd_state  = rd_state;
      next_trans_cnt = trans_cnt;
      next_out_valid = out_valid;
      next_data_out  = data_out;
      mem_wr         = 1'b0;
      mem_rd         = 1'b0;

      if (!s3.mrs_n) begin
         // Mode is latched only here and held until the next master reset
         next_fall_through_mode      = ({s3.fl_n, s3.rxi_n, s3.wxi_n} == fifo_pkg::FALL_THROUGH_MODE_STRAP); // R1 R17
         next_mem_count = '0;
         next_wr_ptr    = '0;
         next_rd_ptr    = '0;
         next_buf_count = 2'h0;
         next_empty_off = fifo_pkg::default_offset(DEPTH); // R14
         next_full_off  = fifo_pkg::default_offset(DEPTH); // R9
         next_load_sel  = 1'b0;
         next_rd_state  = fifo_pkg::RD_IDLE;
         next_trans_cnt = 2'h0;
         next_out_valid = 1'b0;
         next_data_out  = fifo_pkg::DATA_RESET;
      end else begin
         // ----------------------------------------------------------------
         // Write side
         // ----------------------------------------------------------------
         if (buf_out_valid && buf_out_ready) begin
            mem_wr           = 1'b1;
            next_wr_ptr      = wr_ptr + 1'b1;
            next_buf_data[0] = buf_data[1];
            next_buf_count   = buf_count - 2'h1;
            next_mem_count   = mem_count + 1'b1;
         end
         if (wr_rise && !s3.wen_n && !s3.ld_n) begin
            if (!load_sel) begin
               next_empty_off = s3.data[fifo_pkg::OFFSET_W-1:0]; // R16
            end else begin
               next_full_off = s3.data[fifo_pkg::OFFSET_W-1:0];  // R16
            end
            next_load_sel = ~load_sel; // R16
         end else if (buf_in_valid && buf_in_ready && room) begin // R10
            next_buf_data[next_buf_count[0]] = s3.data;
            next_buf_count                   = next_buf_count + 2'h1;
         end

         // ----------------------------------------------------------------
         // Read side
         // ----------------------------------------------------------------
         unique case (rd_state)
            fifo_pkg::RD_IDLE: begin
               if (!fall_through_mode) begin
                  // Reads on an empty store are dropped
                  if (rd_rise && !s3.ren_n && mem_count != '0) begin // R2 R15
                     mem_rd        = 1'b1;
                     next_rd_state = fifo_pkg::RD_LOAD;
                  end
               end else if (!out_valid) begin
                  if (mem_count != '0) begin
                     next_rd_state  = fifo_pkg::RD_COUNT; // R3
                     next_trans_cnt = 2'h0;
                  end
               end else if (rd_rise && !s3.ren_n) begin
                  if (mem_count != '0) begin
                     mem_rd        = 1'b1;
                     next_rd_state = fifo_pkg::RD_LOAD;
                  end else begin
                     next_out_valid = 1'b0;
                  end
               end
            end
            fifo_pkg::RD_COUNT: begin
               if (rd_trans) begin
                  if (trans_cnt == LAST_T) begin // R3
                     mem_rd        = 1'b1;
                     next_rd_state = fifo_pkg::RD_LOAD;
                  end else begin
                     next_trans_cnt = trans_cnt + 2'h1;
                  end
               end
            end
            fifo_pkg::RD_LOAD: begin
               next_data_out  = rd_data;
               next_out_valid = 1'b1;
               next_rd_state  = fifo_pkg::RD_IDLE;
            end
         endcase
         if (mem_rd) begin
            next_rd_ptr    = rd_ptr + 1'b1;
            next_mem_count = next_mem_count - 1'b1; // R11 R12 R15
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Flags follow the word count of the store; in fall-through mode the
   // empty flag instead tells whether the output holds a word.
   always_comb begin
      cnt_w = CMP_W'(next_mem_count);
      next_flags.empty_n  = next_fall_through_mode ? next_out_valid : (cnt_w != '0); // R5 R15
      next_flags.full_n   = (cnt_w != DEPTH_W);                        // R10 R11
      next_flags.half_n   = (cnt_w <= HALF_W);                         // R7 R12
      next_flags.aempty_n = (cnt_w > CMP_W'(next_empty_off));          // R6 R13
      next_flags.afull_n  = ((cnt_w + CMP_W'(next_full_off)) < DEPTH_W); // R8 R12
   end

   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         fall_through_mode      <= 1'b0;
         mem_count <= '0;
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         buf_data  <= '0;
         buf_count <= 2'h0;
         empty_off <= fifo_pkg::default_offset(DEPTH);
         full_off  <= fifo_pkg::default_offset(DEPTH);
         load_sel  <= 1'b0;
         rd_state  <= fifo_pkg::RD_IDLE;
         trans_cnt <= 2'h0;
         out_valid <= 1'b0;
         data_out  <= fifo_pkg::DATA_RESET;
         flags     <= fifo_pkg::FLAGS_RESET;
      end else begin
         fall_through_mode      <= next_fall_through_mode;
         mem_count <= next_mem_count;
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         buf_data  <= next_buf_data;
         buf_count <= next_buf_count;
         empty_off <= next_empty_off;
         full_off  <= next_full_off;
         load_sel  <= next_load_sel;
         rd_state  <= next_rd_state;
         trans_cnt <= next_trans_cnt;
         out_valid <= next_out_valid;
         data_out  <= next_data_out;
         flags     <= next_flags;
      end
   end

   assign DATA_OUT                = data_out;
   assign EMPTY_FLAG_N_OUT        = flags.empty_n;
   assign FULL_FLAG_N_OUT         = flags.full_n;
   assign HALF_FULL_FLAG_N_OUT    = flags.half_n;
   assign ALMOST_EMPTY_FLAG_N_OUT = flags.aempty_n;
   assign ALMOST_FULL_FLAG_N_OUT  = flags.afull_n;
   assign FALL_THROUGH_MODE_OUT   = fall_through_mode;

endmodule : fifo_flag_core

// ===== pkg/fifo_pkg.sv
// Package: constants, carriers and helpers of the status-flag FIFO core
//
// Overview of operation
// R1 - Mode is taken from three strap pins only while master reset is low.
// R2 - Standard mode: a written word reaches the output only on an enabled read edge.
// R3 - Fall-through: first word shows after three read clock transitions, no enable.
// R4 - Writer holds write enable low with data; a write clock rise captures it.
// R5 - Standard mode: empty flag goes high after the first write into an empty FIFO.
// R6 - Almost-empty flag goes high once stored count reaches empty offset plus one.
// R7 - Half-full flag goes low when stored count reaches half depth plus one.
// R8 - Almost-full flag goes low once stored count reaches depth minus full offset.
// R9 - Default full offset is 31, 63 or 127 by depth.
// R10 - Full flag goes low when count equals depth; further writes are dropped.
// R11 - The first read from a full FIFO returns the full flag high.
// R12 - Reads below thresholds return almost-full and half-full flags high.
// R13 - Almost-empty flag goes low when stored count falls to the empty offset.
// R14 - Default empty offset is 31, 63 or 127 by depth.
// R15 - Reading the last word drives empty flag low; reads while empty are ignored.
// R16 - Offset load with write enable low loads empty then full offset, alternately.
// R17 - Strap pattern selects the mode, which holds until the next master reset.
// R18 - Link clocks and pins are synchronised before any flag decision.
package fifo_pkg;

   // ----------------------------------------------------------------
   // Sizes and timing
   // ----------------------------------------------------------------
   localparam int DATA_W           = 18;
   localparam int OFFSET_W         = 12;
   localparam int DEPTH_DEFAULT    = 256;
   localparam int CLOCK_PERIOD_NS  = 10;
   localparam int FALL_THROUGH_MODE_TRANSITIONS = 3;

   // ----------------------------------------------------------------
   // Straps {first_load_n, read_expansion_n, write_expansion_n}
   // ----------------------------------------------------------------
   localparam logic [2:0] FALL_THROUGH_MODE_STRAP = 3'h2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   // Flag order {empty_n, full_n, half_n, aempty_n, afull_n}
   localparam logic [4:0]        FLAGS_RESET = 5'h0d;
   localparam logic [DATA_W-1:0] DATA_RESET  = 18'h00000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              mrs_n;
      logic              fl_n;
      logic              rxi_n;
      logic              wxi_n;
      logic              ld_n;
      logic              wen_n;
      logic              ren_n;
      logic              wclk;
      logic              rclk;
      logic [DATA_W-1:0] data;
   } pins_s;

   typedef struct packed {
      logic empty_n;
      logic full_n;
      logic half_n;
      logic aempty_n;
      logic afull_n;
   } flags_s;

   typedef enum logic [2:0] {
      RD_IDLE  = 3'h1,
      RD_COUNT = 3'h2,
      RD_LOAD  = 3'h4
   } rd_state_e;

   // ----------------------------------------------------------------
   // Default offset for both partial flags
   // ----------------------------------------------------------------
   function automatic logic [OFFSET_W-1:0] default_offset(input int depth);
      if (depth <= 256) begin
         return 12'h01f; // R9 R14
      end else if (depth <= 512) begin
         return 12'h03f; // R9 R14
      end
      return 12'h07f; // R9 R14
   endfunction : default_offset

endpackage : fifo_pkg

// ===== hdl/fifo_ram.sv
// Simple dual-port word store with registered read data
`timescale 1ns/1ps
module fifo_ram #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 256
) (
   input  wire logic                     clock_in,
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   input  wire logic                     rd_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic      [WIDTH-1:0]         rd_data_out
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      if (rd_en_in) begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule : fifo_ram

// ===== dv/fifo_link_model.sv
// Far-side model: free-running write and read link clocks of unrelated phase
`timescale 1ns/1ps
module fifo_link_model (
   output logic write_clock_out,
   output logic read_clock_out
);
   // ----------------------------------------------------------------
   // Link clocks, 125 ns period each
   // ----------------------------------------------------------------
   initial begin
      write_clock_out = 1'b0;
      forever #62.5 write_clock_out = ~write_clock_out;
   end

   // Read link starts 37 ns late so the links never line up
   initial begin
      read_clock_out = 1'b0;
      #37;
      forever #62.5 read_clock_out = ~read_clock_out;
   end
endmodule : fifo_link_model

// ===== dv/fifo_flag_core_assertions.sv
// Checker: port-level properties of the status-flag FIFO core
`timescale 1ns/1ps
module fifo_flag_core_assertions (
   input wire logic                        CLOCK_IN,
   input wire logic                        RSTN_IN,
   input wire logic                        MASTER_RESET_N_IN,
   input wire logic                        WRITE_CLOCK_IN,
   input wire logic                        WRITE_ENABLE_N_IN,
   input wire logic                        READ_CLOCK_IN,
   input wire logic                        READ_ENABLE_N_IN,
   input wire logic [fifo_pkg::DATA_W-1:0] DATA_OUT,
   input wire logic                        EMPTY_FLAG_N_OUT,
   input wire logic                        FULL_FLAG_N_OUT,
   input wire logic                        HALF_FULL_FLAG_N_OUT,
   input wire logic                        ALMOST_EMPTY_FLAG_N_OUT,
   input wire logic                        ALMOST_FULL_FLAG_N_OUT,
   input wire logic                        FALL_THROUGH_MODE_OUT
);
   // ----------------------------------------------------------------
   // Ages of the last write and read edges
   // ----------------------------------------------------------------
   logic       wclk_q;
   logic       rclk_q;
   logic [3:0] wr_age;
   logic [3:0] rd_age;
   logic [7:0] mr_hist;
   logic [3:0] next_wr_age;
   logic [3:0] next_rd_age;

   // Offset loads count as writes: they may move the partial thresholds
   always_comb begin
      next_wr_age = (wr_age == 4'hf) ? wr_age : wr_age + 4'h1;
      next_rd_age = (rd_age == 4'hf) ? rd_age : rd_age + 4'h1;
      if (WRITE_CLOCK_IN && !wclk_q && !WRITE_ENABLE_N_IN) begin
         next_wr_age = 4'h0;
      end
      if ((READ_CLOCK_IN && !rclk_q && !READ_ENABLE_N_IN) || !MASTER_RESET_N_IN) begin
         next_rd_age = 4'h0;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         wclk_q  <= 1'b0;
         rclk_q  <= 1'b0;
         wr_age  <= 4'hf;
         rd_age  <= 4'hf;
         mr_hist <= 8'h00;
      end else begin
         wclk_q  <= WRITE_CLOCK_IN;
         rclk_q  <= READ_CLOCK_IN;
         wr_age  <= next_wr_age;
         rd_age  <= next_rd_age;
         mr_hist <= {mr_hist[6:0], MASTER_RESET_N_IN};
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RSTN_IN);

   a_mode_hold: assert property ($changed(FALL_THROUGH_MODE_OUT) |-> !(&mr_hist))
      else $error("mode moved");
   a_data_hold: assert property ($changed(DATA_OUT) && !FALL_THROUGH_MODE_OUT
      |-> rd_age <= 4'ha)
      else $error("word moved");
   a_empty_rise: assert property ($rose(EMPTY_FLAG_N_OUT) && !FALL_THROUGH_MODE_OUT
      |-> wr_age <= 4'ha)
      else $error("empty rose");
   a_empty_fall: assert property ($fell(EMPTY_FLAG_N_OUT) |-> rd_age <= 4'ha)
      else $error("empty fell");
   a_empty_order: assert property (!EMPTY_FLAG_N_OUT && !FALL_THROUGH_MODE_OUT |->
      !ALMOST_EMPTY_FLAG_N_OUT && HALF_FULL_FLAG_N_OUT && FULL_FLAG_N_OUT)
      else $error("empty flags");
   a_full_order: assert property (!FULL_FLAG_N_OUT |->
      !ALMOST_FULL_FLAG_N_OUT && !HALF_FULL_FLAG_N_OUT)
      else $error("full flags");
   a_full_fall: assert property ($fell(FULL_FLAG_N_OUT) |-> wr_age <= 4'ha)
      else $error("full fell");
   a_full_rise: assert property ($rose(FULL_FLAG_N_OUT) |-> rd_age <= 4'ha)
      else $error("full rose");
   a_aempty_rise: assert property ($rose(ALMOST_EMPTY_FLAG_N_OUT) |-> wr_age <= 4'ha)
      else $error("aempty rose");
   a_aempty_fall: assert property ($fell(ALMOST_EMPTY_FLAG_N_OUT) && !FALL_THROUGH_MODE_OUT
      |-> rd_age <= 4'ha)
      else $error("aempty fell");
   a_half_fall: assert property ($fell(HALF_FULL_FLAG_N_OUT) |-> wr_age <= 4'ha)
      else $error("half fell");
   a_afull_fall: assert property ($fell(ALMOST_FULL_FLAG_N_OUT) |-> wr_age <= 4'ha)
      else $error("afull fell");
endmodule : fifo_flag_core_assertions

bind fifo_flag_core fifo_flag_core_assertions CHECK (
   .CLOCK_IN(CLOCK_IN),
   .RSTN_IN(RSTN_IN),
   .MASTER_RESET_N_IN(MASTER_RESET_N_IN),
   .WRITE_CLOCK_IN(WRITE_CLOCK_IN),
   .WRITE_ENABLE_N_IN(WRITE_ENABLE_N_IN),
   .READ_CLOCK_IN(READ_CLOCK_IN),
   .READ_ENABLE_N_IN(READ_ENABLE_N_IN),
   .DATA_OUT(DATA_OUT),
   .EMPTY_FLAG_N_OUT(EMPTY_FLAG_N_OUT),
   .FULL_FLAG_N_OUT(FULL_FLAG_N_OUT),
   .HALF_FULL_FLAG_N_OUT(HALF_FULL_FLAG_N_OUT),
   .ALMOST_EMPTY_FLAG_N_OUT(ALMOST_EMPTY_FLAG_N_OUT),
   .ALMOST_FULL_FLAG_N_OUT(ALMOST_FULL_FLAG_N_OUT),
   .FALL_THROUGH_MODE_OUT(FALL_THROUGH_MODE_OUT)
);

// ===== dv/tb.sv
// Testbench: writer and reader tasks exercising the status-flag FIFO core
`timescale 1ns/1ps
module tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                        clock;
   logic                        rstn;
   logic                        mrst_n;
   logic [2:0]                  straps;
   logic                        ld_n;
   logic                        wclk;
   logic                        wen_n;
   logic [fifo_pkg::DATA_W-1:0] din;
   logic                        rclk;
   logic                        ren_n;
   logic [fifo_pkg::DATA_W-1:0] dout;
   fifo_pkg::flags_s            flags;
   logic                        ft_mode;
   logic [fifo_pkg::DATA_W-1:0] wr_word;
   logic [fifo_pkg::DATA_W-1:0] rd_word;
   int                          err_total;
   int                          num_checks;

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   fifo_flag_core #(.DEPTH(256)) DUT (
      .CLOCK_IN(clock), .RSTN_IN(rstn), .MASTER_RESET_N_IN(mrst_n),
      .FIRST_LOAD_N_IN(straps[2]), .READ_EXPANSION_N_IN(straps[1]),
      .WRITE_EXPANSION_N_IN(straps[0]), .OFFSET_LOAD_N_IN(ld_n),
      .WRITE_CLOCK_IN(wclk), .WRITE_ENABLE_N_IN(wen_n), .DATA_IN(din),
      .READ_CLOCK_IN(rclk), .READ_ENABLE_N_IN(ren_n), .DATA_OUT(dout),
      .EMPTY_FLAG_N_OUT(flags.empty_n), .FULL_FLAG_N_OUT(flags.full_n),
      .HALF_FULL_FLAG_N_OUT(flags.half_n), .ALMOST_EMPTY_FLAG_N_OUT(flags.aempty_n),
      .ALMOST_FULL_FLAG_N_OUT(flags.afull_n), .FALL_THROUGH_MODE_OUT(ft_mode)
   );

   fifo_link_model LINK (
      .write_clock_out(wclk),
      .read_clock_out(rclk)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Flags settle within five cycles of a link edge
   task automatic flags_are(input logic [4:0] exp);
      repeat (10) @(posedge clock);
      chk("flags", 18'(exp), 18'(flags));
   endtask : flags_are

   task automatic mreset(input logic [2:0] s);
      @(posedge clock);
      straps <= s;
      mrst_n <= 1'b0;
      repeat (20) @(posedge clock);
      mrst_n <= 1'b1;
      repeat (10) @(posedge clock);
   endtask : mreset

   // Inputs move on the falling link edge, so each rise sees them settled
   task automatic write_n(input int n, input logic load, input logic [17:0] first,
                          input logic [17:0] step);
      @(negedge wclk);
      @(posedge clock);
      ld_n  <= ~load;
      wen_n <= 1'b0;
      din   <= first;
      for (int i = 1; i < n; i++) begin
         @(negedge wclk);
         @(posedge clock);
         din <= first + step * 18'(i);
      end
      @(negedge wclk);
      @(posedge clock);
      wen_n <= 1'b1;
      ld_n  <= 1'b1;
   endtask : write_n

   task automatic wr(input int n);
      write_n(n, 1'b0, wr_word, 18'h00001);
      wr_word = wr_word + 18'(n);
   endtask : wr

   // With live clear, reads hit an empty store and the word must hold
   task automatic rd(input int n, input logic live);
      @(negedge rclk);
      @(posedge clock);
      ren_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(negedge rclk);
         @(posedge clock);
         if (i == n - 1) begin
            ren_n <= 1'b1;
         end
         @(posedge clock);
         chk("word", live ? rd_word : rd_word - 18'h1, dout);
         rd_word += 18'(live);
      end
   endtask : rd

   task automatic wf(input int n, input logic [4:0] exp);
      wr(n);
      flags_are(exp);
   endtask : wf

   task automatic rf(input int n, input logic [4:0] exp);
      rd(n, 1'b1);
      flags_are(exp);
   endtask : rf

   task automatic give_verdict();
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (40000) @(posedge clock);
      err_total++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      err_total = 0;
      num_checks = 0;
      {rstn, mrst_n, ld_n, wen_n, ren_n} = 5'h07;
      straps = 3'h7;
      din = 18'h00000;
      wr_word = 18'h00100;
      rd_word = 18'h00100;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      mreset(3'h7);
      chk("mode", 18'h0, {17'h0, ft_mode});
      flags_are(5'h0d);
      wf(1, 5'h1d);
      chk("held", 18'h0, dout);
      rf(1, 5'h0d);
      rd(2, 1'b0);
      wf(31, 5'h1d);
      wf(1, 5'h1f);
      wf(96, 5'h1f);
      wf(1, 5'h1b);
      wf(95, 5'h1b);
      wf(1, 5'h1a);
      wf(30, 5'h1a);
      wf(1, 5'h12);
      wf(1, 5'h12);
      rf(1, 5'h1a);
      rf(30, 5'h1a);
      rf(1, 5'h1b);
      rf(95, 5'h1b);
      rf(1, 5'h1f);
      rf(96, 5'h1f);
      rf(1, 5'h1d);
      rf(31, 5'h0d);
      rd_word = wr_word;
      // Offsets: empty 5, full 250, then empty 3
      write_n(2, 1'b1, 18'h00005, 18'h000f5);
      write_n(1, 1'b1, 18'h00003, 18'h00000);
      flags_are(5'h0d);
      wf(3, 5'h1d);
      wf(1, 5'h1f);
      wf(2, 5'h1e);
      rf(6, 5'h0d);
      mreset(fifo_pkg::FALL_THROUGH_MODE_STRAP);
      chk("mode", 18'h1, {17'h0, ft_mode});
      wr(1);
      chk("early", 18'h0, dout);
      repeat (30) @(posedge clock);
      chk("fall", wr_word - 18'h1, dout);
      chk("ready", 18'h1, {17'h0, flags.empty_n});
      straps <= 3'h7;
      repeat (10) @(posedge clock);
      chk("mode", 18'h1, {17'h0, ft_mode});
      give_verdict();
   end
endmodule : tb
